/* File: hdl/prsc_hold_timer.sv */
// Purpose: Millisecond timebase and saturating elapsed-time counter.
// Assumes: run and clear come from logic on the same clock.
// Notes:   The prescaler restarts with each run, so timing starts at the press.
`timescale 1ns/1ps
module prsc_hold_timer
    import prsc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = CYCLES_PER_MS
) (
    // Clock and reset.
    input  wire logic   i_clock,
    input  wire logic   i_rstn,
    // Control side.
    prsc_timer_if.timer tmr
);
    logic [23:0]     pre_q;
    logic [MS_W-1:0] ms_q;
    logic            tick;

    assign tick     = tmr.run && (pre_q == 24'(TICK_CYCLES - 1));
    assign tmr.step = tick && (ms_q != MS_MAX);
    assign tmr.elapsed = ms_q;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_q <= '0;
        end else if (tmr.clear || !tmr.run || tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 24'h1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            ms_q <= '0;
        end else if (tmr.clear) begin
            ms_q <= '0;
        end else if (tmr.step) begin
            ms_q <= ms_q + 14'h1;
        end
    end
endmodule // prsc_hold_timer

/* File: hdl/prsc_pkg.sv */
// Purpose: Shared constants for the push-button reset and ship control block.
// Assumes: 10 MHz clock; hold timing counted in whole milliseconds.
// Notes:   Times are in ms; cycle counts are derived from the clock rate.
package prsc_pkg;
    localparam int unsigned CLOCK_HZ     = 10_000_000;
    localparam int unsigned MS_PER_S     = 1000;
    localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
    localparam int          MS_W         = 14;
    localparam logic [MS_W-1:0] MS_MAX   = 14'h3fff;

    // Register map.
    localparam logic [7:0] ADDR_BUTTON_TIMING = 8'h30;
    localparam logic [7:0] ADDR_DEVICE_CTRL   = 8'h35;
    localparam logic [7:0] RST_BUTTON_TIMING  = 8'h2a;
    localparam logic [7:0] RST_DEVICE_CTRL    = 8'h10;
    localparam logic [7:0] MASK_BUTTON_TIMING = 8'hfe;
    localparam logic [7:0] MASK_DEVICE_CTRL   = 8'hb4;

    // Field positions in button_timing_control.
    localparam int BT_SUPPLY_GATE = 7;
    localparam int BT_WAKE1       = 6;
    localparam int BT_WAKE2       = 5;
    localparam int BT_WARN_LO     = 3;
    localparam int BT_HOLD_LO     = 1;
    // Field positions in device_reset_ship_control.
    localparam int DC_SHIP_EN     = 7;
    localparam int DC_RESTART_LO  = 4;
    localparam int DC_INT_MASK    = 2;
    localparam int DC_HARD_RESET  = 1;
    localparam int DC_SOFT_RESET  = 0;

    // Long press action codes.
    localparam logic [1:0] LP_HARD_RESET = 2'h0;
    localparam logic [1:0] LP_NOTHING    = 2'h1;

    // Threshold times in ms.
    localparam logic [MS_W-1:0] T_WAKE1_SHORT = 14'd125;
    localparam logic [MS_W-1:0] T_WAKE1_LONG  = 14'd500;
    localparam logic [MS_W-1:0] T_WAKE2_SHORT = 14'd1000;
    localparam logic [MS_W-1:0] T_WAKE2_LONG  = 14'd2000;
    localparam logic [MS_W-1:0] T_WARN_0      = 14'd500;
    localparam logic [MS_W-1:0] T_WARN_1      = 14'd1000;
    localparam logic [MS_W-1:0] T_WARN_2      = 14'd1500;
    localparam logic [MS_W-1:0] T_WARN_3      = 14'd2000;
    localparam logic [MS_W-1:0] T_HOLD_0      = 14'd4000;
    localparam logic [MS_W-1:0] T_HOLD_1      = 14'd8000;
    localparam logic [MS_W-1:0] T_HOLD_2      = 14'd10000;
    localparam logic [MS_W-1:0] T_HOLD_3      = 14'd14000;
    localparam logic [MS_W-1:0] T_RESTART_0   = 14'd600;
    localparam logic [MS_W-1:0] T_RESTART_1   = 14'd1200;
    localparam logic [MS_W-1:0] T_RESTART_2   = 14'd2400;
    localparam logic [MS_W-1:0] T_RESTART_3   = 14'd5000;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_OFF  = 3'b010,
        ST_SHIP = 3'b100
    } prsc_state_e;

    function automatic logic [MS_W-1:0] prsc_pick(input logic [1:0] code,
            input logic [MS_W-1:0] t0, input logic [MS_W-1:0] t1,
            input logic [MS_W-1:0] t2, input logic [MS_W-1:0] t3);
        unique case (code)
            2'h0: prsc_pick = t0;
            2'h1: prsc_pick = t1;
            2'h2: prsc_pick = t2;
            2'h3: prsc_pick = t3;
        endcase
    endfunction
endpackage

/* File: hdl/prsc_timer_if.sv */
// Purpose: Carries hold-timer control and count between the control and timer.
// Assumes: Single clock domain.
// Notes:   step pulses once per elapsed millisecond.
`timescale 1ns/1ps
interface prsc_timer_if;
    import prsc_pkg::*;
    logic            run;
    logic            clear;
    logic            step;
    logic [MS_W-1:0] elapsed;
    modport timer (input run, input clear, output step, output elapsed);
    modport ctrl  (output run, output clear, input step, input elapsed);
endinterface

/* File: hdl/prsc_top.sv */
// Purpose: Push-button hold timing, hardware/software reset and ship mode control.
// Assumes: Register port driven by the serial interface logic, one access per cycle.
// Notes:   Pins pass a three-stage synchroniser before use.
// What this block does
// - Gate bit clear: hold time reached issues hardware reset regardless of supply.
// - Gate bit set: hardware reset only if supply valid when hold reached.
// - First wake threshold 125 ms or 500 ms; select resets clear.
// - Second wake threshold 1 s or 2 s; select resets set.
// - Reset warning at hold time minus 0.5/1.0/1.5/2.0 s, default code 01.
// - Reset hold time 4/8/10/14 s, default code 01 gives 8 s.
// - Ship enable set: enter ship mode when supply invalid and button high.
// - After button hardware reset wait 0.6/1.2/2.4/5 s before power up; the reset defaults the code, so 1.2 s unless written while off.
// - Global mask bit set suppresses all interrupt outputs.
// - Hard reset command cycles rails except always-on and defaults registers.
// - Soft reset command defaults registers without cycling rails.
// - Button timing register at 0x30 resets to 0x2a; bit 0 reads zero.
// - Device control register at 0x35 resets to 0x10; bits 6,3 zero.
// - Long press: 00 hardware reset, 01 nothing, 1x enter ship mode.
`timescale 1ns/1ps
module prsc_top
    import prsc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = CYCLES_PER_MS
) (
    // Clock and reset.
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    // Register port.
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_rd,
    output logic      [7:0] o_reg_rdata,
    // Pins and system inputs.
    input  wire logic       i_button_n,
    input  wire logic       i_vin_valid,
    input  wire logic [1:0] i_long_press_action,
    input  wire logic       i_int_req,
    // Outputs.
    output logic            o_wake1,
    output logic            o_wake2,
    output logic            o_reset_warn,
    output logic            o_rails_en,
    output logic            o_ship_mode,
    output logic            o_int_n
);
    localparam int NSYNC = 2;

    prsc_timer_if tif ();

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] lvl_q;
    logic             pressed;
    logic             vin_ok;
    logic [7:0]       btn_q;
    logic [7:0]       dev_q;
    logic [MS_W-1:0]  thr_wake1;
    logic [MS_W-1:0]  thr_wake2;
    logic [MS_W-1:0]  thr_hold;
    logic [MS_W-1:0]  thr_warn;
    logic [MS_W-1:0]  thr_restart;
    logic             hit_hold;
    logic             button_hard;
    logic             cmd_hard;
    logic             cmd_soft;
    logic             regs_default;
    logic             off_done;
    prsc_state_e      state_q;
    prsc_state_e      state_d;
    logic [MS_W-1:0]  off_ms_q;
    logic [23:0]      off_pre_q;

    assign pin_raw = {i_vin_valid, i_button_n};

    // A level changes only once the second and third stages agree.
    for (genvar g = 0; g < NSYNC; g++) begin : g_sync
        always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
                s1_q[g]  <= 1'b1;
                s2_q[g]  <= 1'b1;
                s3_q[g]  <= 1'b1;
                lvl_q[g] <= 1'b1;
            end else begin
                s1_q[g] <= pin_raw[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                if (s2_q[g] == s3_q[g]) begin
                    lvl_q[g] <= s3_q[g];
                end
            end
        end
    end

    assign pressed = !lvl_q[0];
    assign vin_ok  = lvl_q[1];

    assign tif.run   = pressed && (state_q == ST_RUN);
    assign tif.clear = !pressed;

    prsc_hold_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .tmr     (tif.timer)
    );

    assign thr_wake1 = btn_q[BT_WAKE1] ? T_WAKE1_LONG : T_WAKE1_SHORT;
    assign thr_wake2 = btn_q[BT_WAKE2] ? T_WAKE2_LONG : T_WAKE2_SHORT;
    assign thr_hold = prsc_pick(btn_q[BT_HOLD_LO +: 2], T_HOLD_0, T_HOLD_1, T_HOLD_2, T_HOLD_3);
    assign thr_warn = thr_hold - prsc_pick(btn_q[BT_WARN_LO +: 2],
                                           T_WARN_0, T_WARN_1, T_WARN_2, T_WARN_3);
    assign thr_restart = prsc_pick(dev_q[DC_RESTART_LO +: 2],
                                   T_RESTART_0, T_RESTART_1, T_RESTART_2, T_RESTART_3);

    // Crossings are caught on the step, so each threshold fires once per press.
    assign hit_hold = tif.step && ((tif.elapsed + 14'h1) == thr_hold);

    assign button_hard = hit_hold && (i_long_press_action == LP_HARD_RESET)
                         && (!btn_q[BT_SUPPLY_GATE] || vin_ok);

    assign cmd_hard = i_reg_wr && (i_reg_addr == ADDR_DEVICE_CTRL) && i_reg_wdata[DC_HARD_RESET];
    assign cmd_soft = i_reg_wr && (i_reg_addr == ADDR_DEVICE_CTRL) && i_reg_wdata[DC_SOFT_RESET];
    assign regs_default = cmd_hard || cmd_soft || button_hard;

    assign off_done = (state_q == ST_OFF) && (off_ms_q >= thr_restart);

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            btn_q <= RST_BUTTON_TIMING;
        end else if (regs_default) begin
            btn_q <= RST_BUTTON_TIMING;
        end else if (i_reg_wr && (i_reg_addr == ADDR_BUTTON_TIMING)) begin
            btn_q <= i_reg_wdata & MASK_BUTTON_TIMING;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            dev_q <= RST_DEVICE_CTRL;
        end else if (regs_default) begin
            dev_q <= RST_DEVICE_CTRL;
        end else if (i_reg_wr && (i_reg_addr == ADDR_DEVICE_CTRL)) begin
            dev_q <= i_reg_wdata & MASK_DEVICE_CTRL;
        end
    end

    // Unmapped addresses read as zero.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                ADDR_BUTTON_TIMING: o_reg_rdata <= btn_q;
                ADDR_DEVICE_CTRL:   o_reg_rdata <= dev_q;
                default:            o_reg_rdata <= 8'h00;
            endcase
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (button_hard || cmd_hard) begin
                    state_d = ST_OFF;
                end else if (hit_hold && i_long_press_action[1]) begin
                    state_d = ST_SHIP;
                end else if (dev_q[DC_SHIP_EN] && !vin_ok && !pressed) begin
                    state_d = ST_SHIP;
                end
            end
            ST_OFF: begin
                if (off_done) begin
                    state_d = ST_RUN;
                end
            end
            // Ship mode is left by a press or by a valid supply.
            ST_SHIP: begin
                if (pressed || vin_ok) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // The restart delay has its own timer, because a press or release while off
    // would otherwise clear or freeze the hold counter and upset the wait.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            off_pre_q <= '0;
            off_ms_q  <= '0;
        end else if (state_q != ST_OFF) begin
            off_pre_q <= '0;
            off_ms_q  <= '0;
        end else if (off_pre_q == 24'(TICK_CYCLES - 1)) begin
            off_pre_q <= '0;
            off_ms_q  <= off_ms_q + 14'h1;
        end else begin
            off_pre_q <= off_pre_q + 24'h1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wake1      <= 1'b0;
            o_wake2      <= 1'b0;
            o_reset_warn <= 1'b0;
        end else begin
            o_wake1      <= tif.step && ((tif.elapsed + 14'h1) == thr_wake1);
            o_wake2      <= tif.step && ((tif.elapsed + 14'h1) == thr_wake2);
            o_reset_warn <= tif.step && ((tif.elapsed + 14'h1) == thr_warn);
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rails_en  <= 1'b1;
            o_ship_mode <= 1'b0;
        end else begin
            o_rails_en  <= (state_d == ST_RUN);
            o_ship_mode <= (state_d == ST_SHIP);
        end
    end

    assign o_int_n = !(i_int_req && !dev_q[DC_INT_MASK]);
endmodule // prsc_top

/* File: tb/prsc_button_model.sv */
// Purpose: Push-button that holds the pin low for a requested count.
// Assumes: The pin has a pull-up, so a released button reads high.
// Notes:   Hold count is in clock cycles from the request edge.
`timescale 1ns/1ps
module prsc_button_model (
    // Clock and request.
    input  wire logic        i_clock,
    input  wire logic        i_press,
    input  wire logic [31:0] i_hold,
    // Button pin.
    output logic             o_button_n
);
    int unsigned left_q = 0;
    initial o_button_n = 1'b1;
    always @(posedge i_clock) begin
        if (i_press) begin
            left_q <= i_hold;
            o_button_n <= 1'b0;
        end else if (left_q > 1) begin
            left_q <= left_q - 1;
        end else begin
            o_button_n <= 1'b1;
        end
    end
endmodule // prsc_button_model

/* File: tb/prsc_monitor.sv */
// Purpose: Port assertions for the button reset and ship control block.
// Assumes: One clock; press age counts from the raw falling edge of the pin.
// Notes:   Synchroniser lag makes the ages lower bounds only.
`timescale 1ns/1ps
module prsc_monitor
    import prsc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = CYCLES_PER_MS
) (
    // Watched ports.
    input wire logic       i_clock,
    input wire logic       i_rstn,
    input wire logic [7:0] i_reg_addr,
    input wire logic       i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       i_button_n,
    input wire logic       i_int_req,
    input wire logic       o_wake1,
    input wire logic       o_wake2,
    input wire logic       o_reset_warn,
    input wire logic       o_rails_en,
    input wire logic       o_ship_mode,
    input wire logic       o_int_n
);
    logic [19:0] age_q;
    logic [19:0] off_q;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    // Both counts saturate, so a long idle spell cannot wrap into a false pass.
    always_ff @(posedge i_clock or negedge i_rstn)
        if (!i_rstn) age_q <= '0;
        else if ($fell(i_button_n)) age_q <= '0;
        else if (age_q != '1) age_q <= age_q + 20'h1;
    always_ff @(posedge i_clock or negedge i_rstn)
        if (!i_rstn) off_q <= '0;
        else if (o_rails_en || o_ship_mode) off_q <= '0;
        else if (off_q != '1) off_q <= off_q + 20'h1;
    int_idle_a: assert property (!i_int_req |-> o_int_n)
        else $error("interrupt without request");
    unmapped_zero_a: assert property (i_reg_rd && i_reg_addr != 8'h30 &&
        i_reg_addr != 8'h35 |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    ctrl_rsv_a: assert property (i_reg_rd && i_reg_addr == 8'h35
        |=> (o_reg_rdata & 8'h4b) == 8'h00) else $error("control reserved bit set");
    timing_wr_a: assert property (i_reg_wr && i_reg_addr == 8'h30 ##2 i_reg_rd &&
        i_reg_addr == 8'h30 |=> o_reg_rdata == ($past(i_reg_wdata, 3) & 8'hfe))
        else $error("timing write not read back");
    soft_rst_a: assert property (i_reg_wr && i_reg_addr == 8'h35 && i_reg_wdata[0]
        ##2 i_reg_rd && i_reg_addr == 8'h30 |=> o_reg_rdata == 8'h2a)
        else $error("soft reset left timing set");
    wake1_age_a: assert property (o_wake1 |-> age_q >= 125 * TICK_CYCLES)
        else $error("first wake too early");
    wake2_age_a: assert property (o_wake2 |-> age_q >= 1000 * TICK_CYCLES)
        else $error("second wake too early");
    warn_age_a: assert property (o_reset_warn |-> age_q >= 2000 * TICK_CYCLES)
        else $error("warning too early");
    rails_min_a: assert property ($fell(o_rails_en) && !o_ship_mode |=> !o_rails_en [*8])
        else $error("rails back too soon");
    rails_back_a: assert property (off_q <= 5000 * TICK_CYCLES + 16)
        else $error("rails never restored");
    cover property ($fell(o_rails_en));
    cover property ($rose(o_ship_mode));
    cover property (o_reset_warn);
endmodule // prsc_monitor
bind prsc_top prsc_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.i_clock, .i_rstn,
    .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .i_button_n, .i_int_req,
    .o_wake1, .o_wake2, .o_reset_warn, .o_rails_en, .o_ship_mode, .o_int_n);

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the button reset and ship control block.
// Assumes: TK cycles per millisecond shorten every hold time.
// Notes:   Event times are taken from the press request edge.
`timescale 1ns/1ps
module testbench;
    import prsc_pkg::*;
    localparam int unsigned TK = 2;
    logic        i_clock = 1'b0;
    logic        i_rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0, rd = 1'b0, vin = 1'b1, irq = 1'b0, press = 1'b0;
    logic [1:0]  act = 2'h1;
    logic [31:0] hold = 32'h0, seed = 32'h4d, d;
    logic        ship_seen = 1'b0;
    wire logic   btn_n, w1, w2, warn, rails, ship, int_n;
    wire logic [7:0] rdata;
    int unsigned err_total = 0, cmp_count = 0, cyc = 0, t0 = 0, c = 0;
    int unsigned tw1 = 0, tw2 = 0, twr = 0, toff = 0, ton = 0, n_w1 = 0;

    always #50 i_clock = ~i_clock;
    prsc_top #(.TICK_CYCLES(TK)) dut (.i_clock, .i_rstn, .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_button_n(btn_n), .i_vin_valid(vin), .i_long_press_action(act), .i_int_req(irq),
        .o_wake1(w1), .o_wake2(w2), .o_reset_warn(warn), .o_rails_en(rails),
        .o_ship_mode(ship), .o_int_n(int_n));
    prsc_button_model btn (.i_clock, .i_press(press), .i_hold(hold), .o_button_n(btn_n));

    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (w1) n_w1 <= n_w1 + 1;
        if (w1) tw1 <= cyc - t0;
        if (w2) tw2 <= cyc - t0;
        if (warn) twr <= cyc - t0;
        if (!rails && toff == 0) toff <= cyc - t0;
        if (rails && toff != 0 && ton == 0) ton <= cyc - t0;
        if (ship) ship_seen <= 1'b1;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // Sync and registering add a few cycles, so a small late window is allowed.
    task automatic near(input int unsigned m, input int unsigned e, input string n);
        chk((m >= e && m <= e + 12) ? e : m, e, n);
    endtask
    task automatic close_out();
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge i_clock);
        i_rstn <= 1'b0;
        repeat (4) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(posedge i_clock);
    endtask
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clock);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= v;
        @(posedge i_clock);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
        op(1'b0, a, 8'h00);
        @(negedge i_clock);
        chk(rdata, e, n);
    endtask
    task automatic mark();
        t0 = cyc;
        {tw1, tw2, twr, toff, ton} = '0;
        ship_seen = 1'b0;
    endtask
    task automatic pr(input int unsigned h);
        @(posedge i_clock);
        press <= 1'b1;
        hold <= h;
        mark();
        @(posedge i_clock);
        press <= 1'b0;
        repeat (h + 20) @(posedge i_clock);
    endtask
    task automatic wait_on();
        for (int w = 0; w < 1400 * TK && (toff == 0 || ton == 0); w++) @(posedge i_clock);
    endtask

    initial begin
        do_reset();
        rdc(8'h30, 8'h2a, "timing_reset");
        rdc(8'h35, 8'h10, "ctrl_reset");
        op(1'b1, 8'h31, 8'hff);
        rdc(8'h31, 8'h00, "unmapped");
        repeat (6) begin
            d = xs();
            @(posedge i_clock);
            irq <= d[16];
            op(1'b1, 8'h30, d[7:0]);
            rdc(8'h30, d[7:0] & 8'hfe, "timing_rw");
            op(1'b1, 8'h35, d[15:8] & 8'hfc);
            rdc(8'h35, d[15:8] & 8'hb4, "ctrl_rw");
            chk(int_n, !(d[16] & !d[10]), "int_n");
        end
        op(1'b1, 8'h30, 8'hff);
        op(1'b1, 8'h35, 8'h01);
        rdc(8'h30, 8'h2a, "soft_timing");
        rdc(8'h35, 8'h10, "soft_ctrl");
        chk(rails, 1'b1, "soft_rails");
        op(1'b1, 8'h30, 8'hff);
        mark();
        op(1'b1, 8'h35, 8'h02);
        wait_on();
        chk(toff != 0, 1'b1, "cmd_off");
        near(ton - toff, 1200 * TK, "cmd_restart");
        rdc(8'h30, 8'h2a, "cmd_timing");
        for (int k = 0; k < 5; k++) begin
            do_reset();
            vin <= (k >= 2);
            act <= (k == 2) ? 2'h1 : (k == 3) ? 2'h2 : 2'h0;
            op(1'b1, 8'h30, (k != 0 && k != 3) ? 8'hc0 : 8'h40);
            pr(4000 * TK + 40);
            near(tw1, 500 * TK, "wake1");
            near(tw2, 1000 * TK, "wake2");
            near(twr, 3500 * TK, "warn");
            chk(ship_seen, k == 3, "ship");
            if (k == 0 || k == 4) begin
                near(toff, 4000 * TK, "hold_off");
                wait_on();
                near(ton - toff, 1200 * TK, "restart");
                rdc(8'h30, 8'h2a, "hold_regs");
            end else if (k != 3)
                chk(toff, 0, "no_off");
        end
        do_reset();
        c = n_w1;
        pr(100 * TK);
        pr(100 * TK);
        pr(130 * TK);
        chk(n_w1 - c, 1, "short_press");
        @(posedge i_clock);
        vin <= 1'b0;
        repeat (10) @(negedge i_clock);
        chk(ship, 1'b0, "ship_off");
        op(1'b1, 8'h35, 8'h80);
        repeat (10) @(negedge i_clock);
        chk(ship, 1'b1, "ship_on");
        close_out();
    end

    initial begin
        #(60_000 * 100);
        err_total++;
        close_out();
    end
endmodule // testbench
